/* verilog/instruction_exception_unit.sv */
// How it works
// [RULE_01] trap pushes status, then next address
// [RULE_02] trap vectors via its own number, undelayed
// [RULE_03] undefined code in slot: slot exception
// [RULE_04] pc-changing instruction in slot: slot exception
// [RULE_05] slot exception saves the branch target
// [RULE_06] undefined elsewhere saves its own address
// [RULE_07] stopped fpu makes fp instructions illegal
// [RULE_08] fp exception needs enabled invalid/divide event
// [RULE_09] only ten arithmetic fp ops may trap
// [RULE_10] enabled fp event suspends fpu, tells core
// [RULE_11] fp exception vectors to base plus 0x34
// [RULE_12] fp flags sticky until software clears
// [RULE_13] fp cause rewritten by every fp op
// [RULE_14] overflow, underflow, inexact never trap
// [RULE_15] fp transfer ops never trap
// [RULE_16] blocked sources wait for accepting decode
// [RULE_17] after delayed branch all sources wait
// [RULE_18] after control load/store fp still accepted
// [RULE_19] after fp instruction fp still accepted
// [RULE_20] sp ends on return address, status above
// [RULE_21] each push predecrements sp by four
// [RULE_22] exception choice made within decode
`include "ieu_params.svh"

module instruction_exception_unit
  import ieu_pkg::*;
#(
  parameter logic [31:0] GEN_ILL_OFS = 32'h10,
  parameter logic [31:0] SLOT_ILL_OFS = 32'h18,
  parameter logic [31:0] BUS_ERR_OFS = 32'h24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // decode stage
  input wire logic decValid,
  input wire logic [31:0] decPc,
  input wire logic decUndef,
  input wire logic decIsTrap,
  input wire logic [7:0] decTrapVector,
  input wire logic decIsDelayed,
  input wire logic [31:0] decBranchTarget,
  input wire logic decWritesPc,
  input wire logic decIsCtrlLdSt,
  input wire logic decIsFp,
  input wire logic decIsFpRelated,
  // core state
  input wire logic fpuStop,
  input wire logic [31:0] statusRegister,
  input wire logic [31:0] stackPointer,
  input wire logic [31:0] vectorBase,
  // other exception sources
  input wire logic busErr,
  input wire logic intReq,
  input wire logic [7:0] intVector,
  // fp datapath result
  input wire logic fpuDone,
  input wire ieu_fpop_t fpuOp,
  input wire logic [4:0] fpuEvt,
  input wire logic [31:0] fpuNextPc,
  // memory
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  // software port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  // outputs
  output logic excBusy,
  output logic excFlush,
  output logic fpuSuspend,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  output logic pcLoad,
  output logic [31:0] newPc,
  output logic spLoad,
  output logic [31:0] newSp,
  output logic [31:0] regRdata
);

  // ==========================================================
  // state
  ieu_regs_t s; // registered state
  ieu_regs_t next_s; // next state

  // decode classification
  logic decTake; // decode accepted this cycle
  logic inSlot; // decoded instruction sits in a delay slot
  logic undefEff; // undefined, or fp op with fpu stopped
  logic slotExc; // illegal slot exception
  logic genExc; // general illegal exception
  logic trapExc; // trap exception
  logic instrExc; // any instruction exception
  logic busIntOk; // bus error and interrupt may be taken
  logic fpOk; // fp exception may be taken
  logic fpuCapable; // op class able to trap
  logic fpuRaise; // enabled invalid or divide event
  logic fpscWr; // software writes the fp word
  logic [4:0] vzMask; // invalid and divide bits only

  // ==========================================================
  // decode classification
  always_comb begin
    vzMask = 5'h00;
    vzMask[`IEU_EVT_V] = 1'b1;
    vzMask[`IEU_EVT_Z] = 1'b1;
    decTake = decValid && !s.excBusy;
    inSlot = s.prevDelayed;
    undefEff = decUndef || (fpuStop && (decIsFp || decIsFpRelated)); // RULE_07
    slotExc = inSlot && (undefEff || decWritesPc || decIsTrap); // RULE_03 RULE_04
    genExc = !inSlot && undefEff; // RULE_06
    trapExc = !inSlot && !undefEff && decIsTrap; // RULE_01
    instrExc = slotExc || genExc || trapExc;
    busIntOk = !(s.prevDelayed || s.prevCtrl || s.prevFp); // RULE_17 RULE_18 RULE_19
    fpOk = !s.prevDelayed; // RULE_17 RULE_18 RULE_19
    fpuCapable = (fpuOp <= IEU_FOP_TRC); // RULE_09 RULE_15
    fpuRaise = fpuDone && fpuCapable && ((fpuEvt & s.enable & vzMask) != 5'h00); // RULE_08 RULE_14
    fpscWr = regWrite && (regAddr == `IEU_OFS_FPSC);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.excFlush = 1'b0;
    next_s.pcLoad = 1'b0;
    next_s.spLoad = 1'b0;
    next_s.rdata = `IEU_ZERO32;
    // fp status word: software write first, hardware set wins
    if (fpscWr) begin
      next_s.cause = regWdata[`IEU_FPSC_CAUSE_LSB +: `IEU_EVT_W];
      next_s.enable = regWdata[`IEU_FPSC_ENABLE_LSB +: `IEU_EVT_W];
      next_s.flags = regWdata[`IEU_FPSC_FLAG_LSB +: `IEU_EVT_W];
    end
    if (fpuDone) begin
      next_s.cause = fpuEvt; // RULE_13
      next_s.flags = next_s.flags | fpuEvt; // RULE_12
    end
    // enabled fp event halts the fpu and waits for acceptance
    if (fpuRaise) begin
      next_s.pendFp = 1'b1; // RULE_10 RULE_16
      next_s.fpuSuspend = 1'b1; // RULE_10
      next_s.fpPc = fpuNextPc; // RULE_11
    end
    // bus errors and interrupts are held until accepted
    if (busErr) begin
      next_s.pendBus = 1'b1; // RULE_16
    end
    if (intReq && !s.pendInt) begin
      next_s.pendInt = 1'b1; // RULE_16
      next_s.pendIntOfs = {22'h0, intVector, 2'b00};
    end
    // software reads
    if (regRead) begin
      case (regAddr)
        `IEU_OFS_FPSC: begin
          next_s.rdata[`IEU_FPSC_CAUSE_LSB +: `IEU_EVT_W] = s.cause;
          next_s.rdata[`IEU_FPSC_ENABLE_LSB +: `IEU_EVT_W] = s.enable;
          next_s.rdata[`IEU_FPSC_FLAG_LSB +: `IEU_EVT_W] = s.flags;
        end
        `IEU_OFS_EXCSTAT: begin
          next_s.rdata[1:0] = s.st;
          next_s.rdata[2] = s.pendBus;
          next_s.rdata[3] = s.pendInt;
          next_s.rdata[4] = s.pendFp;
          next_s.rdata[5] = s.fpuSuspend;
          next_s.rdata[6] = s.prevDelayed;
        end
        default: begin
          next_s.rdata = `IEU_ZERO32;
        end
      endcase
    end
    // choose the exception while the instruction is in decode
    if (decTake) begin
      next_s.prevDelayed = decIsDelayed && !instrExc;
      next_s.prevCtrl = decIsCtrlLdSt;
      next_s.prevFp = decIsFp || decIsFpRelated;
      if (decIsDelayed) begin
        next_s.slotTarget = decBranchTarget; // RULE_05
      end
      next_s.excBusy = 1'b1;
      if (slotExc) begin
        next_s.excPc = s.slotTarget; // RULE_05
        next_s.excOfs = SLOT_ILL_OFS; // RULE_03
      end else if (genExc) begin
        next_s.excPc = decPc; // RULE_06
        next_s.excOfs = GEN_ILL_OFS; // RULE_06
      end else if (trapExc) begin
        next_s.excPc = decPc + `IEU_INSTR_BYTES; // RULE_01
        next_s.excOfs = {22'h0, decTrapVector, 2'b00}; // RULE_02
      end else if (s.pendBus && busIntOk) begin
        next_s.excPc = decPc; // RULE_16
        next_s.excOfs = BUS_ERR_OFS;
        next_s.pendBus = busErr;
      end else if (s.pendFp && fpOk) begin
        next_s.excPc = s.fpPc; // RULE_11
        next_s.excOfs = `IEU_FP_VEC_OFFSET; // RULE_11
        next_s.pendFp = fpuRaise;
        next_s.fpuSuspend = fpuRaise;
      end else if (s.pendInt && busIntOk) begin
        next_s.excPc = decPc; // RULE_16
        next_s.excOfs = s.pendIntOfs;
        next_s.pendInt = 1'b0;
      end else begin
        next_s.excBusy = 1'b0;
      end
      // a taken exception squashes the decoded instruction
      if (next_s.excBusy) begin
        next_s.prevDelayed = 1'b0;
        next_s.prevCtrl = 1'b0;
        next_s.prevFp = 1'b0;
        next_s.excFlush = 1'b1; // RULE_22
        next_s.spStart = stackPointer;
        next_s.st = IEU_PUSH_SR;
        next_s.memReq = 1'b1;
        next_s.memWe = 1'b1;
        next_s.memAddr = stackPointer - `IEU_WORD_BYTES; // RULE_21
        next_s.memWdata = statusRegister; // RULE_01 RULE_05
      end
    end
    // stacking and vector fetch sequence
    case (s.st)
      IEU_IDLE: begin
        next_s.st = next_s.st;
      end
      IEU_PUSH_SR: begin
        // status word written; now the return address below it
        if (memAck) begin
          next_s.st = IEU_PUSH_PC;
          next_s.memAddr = s.memAddr - `IEU_WORD_BYTES; // RULE_21 RULE_20
          next_s.memWdata = s.excPc; // RULE_01
        end
      end
      IEU_PUSH_PC: begin
        // return address written; read the vector entry
        if (memAck) begin
          next_s.st = IEU_FETCH_VEC;
          next_s.memWe = 1'b0;
          next_s.memAddr = vectorBase + s.excOfs; // RULE_02 RULE_11
        end
      end
      IEU_FETCH_VEC: begin
        // handler address arrives: jump without a delay slot
        if (memAck) begin
          next_s.st = IEU_IDLE;
          next_s.memReq = 1'b0;
          next_s.pcLoad = 1'b1; // RULE_02
          next_s.newPc = memRdata;
          next_s.spLoad = 1'b1; // RULE_20
          next_s.newSp = s.spStart - `IEU_WORD_BYTES - `IEU_WORD_BYTES;
          next_s.excBusy = 1'b0;
        end
      end
      default: begin
        next_s.st = IEU_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register with clock enable and synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.enable <= `IEU_FPSC_RESET;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign excBusy = s.excBusy;
  assign excFlush = s.excFlush;
  assign fpuSuspend = s.fpuSuspend;
  assign memReq = s.memReq;
  assign memWe = s.memWe;
  assign memAddr = s.memAddr;
  assign memWdata = s.memWdata;
  assign pcLoad = s.pcLoad;
  assign newPc = s.newPc;
  assign spLoad = s.spLoad;
  assign newSp = s.newSp;
  assign regRdata = s.rdata;

  // ==========================================================
  // checks
  property p_trapPc;
    @(posedge sys_clk) disable iff (!rstn)
    ce && decTake && trapExc |=> s.excPc == $past(decPc) + `IEU_INSTR_BYTES
      && s.memWdata == $past(statusRegister);
  endproperty
  a_trapPc: assert property (p_trapPc) // RULE_01
    else $error("trap saved wrong address or status");

  property p_trapVec;
    @(posedge sys_clk) disable iff (!rstn)
    ce && decTake && trapExc |=> s.excOfs[9:2] == $past(decTrapVector);
  endproperty
  a_trapVec: assert property (p_trapVec) // RULE_02
    else $error("trap vector offset wrong");

  property p_slotPc;
    @(posedge sys_clk) disable iff (!rstn)
    ce && decTake && s.prevDelayed && (decUndef || decWritesPc)
      |=> s.excPc == $past(s.slotTarget) && s.excOfs == SLOT_ILL_OFS;
  endproperty
  a_slotPc: assert property (p_slotPc) // RULE_05
    else $error("slot exception saved wrong address");

  property p_genPc;
    @(posedge sys_clk) disable iff (!rstn)
    ce && decTake && !s.prevDelayed && fpuStop && decIsFp
      |=> s.excPc == $past(decPc) && s.excOfs == GEN_ILL_OFS && s.excFlush;
  endproperty
  a_genPc: assert property (p_genPc) // RULE_07
    else $error("stopped fpu op not illegal");

  property p_noFpTrap;
    @(posedge sys_clk) disable iff (!rstn)
    ce && fpuDone && !s.pendFp && (fpuOp == IEU_FOP_XFER
      || (fpuEvt & s.enable & vzMask) == 5'h00) && !decTake |=> !s.pendFp;
  endproperty
  a_noFpTrap: assert property (p_noFpTrap) // RULE_08
    else $error("fp exception without enabled cause");

  property p_flagsSticky;
    @(posedge sys_clk) disable iff (!rstn)
    ce && !fpscWr |=> (s.flags & $past(s.flags)) == $past(s.flags);
  endproperty
  a_flagsSticky: assert property (p_flagsSticky) // RULE_12
    else $error("fp flag dropped without software");

  property p_cause;
    @(posedge sys_clk) disable iff (!rstn)
    ce && fpuDone |=> s.cause == $past(fpuEvt);
  endproperty
  a_cause: assert property (p_cause) // RULE_13
    else $error("fp cause not rewritten");

  property p_afterBranch;
    @(posedge sys_clk) disable iff (!rstn)
    ce && decTake && s.prevDelayed && !instrExc |=> !s.excFlush;
  endproperty
  a_afterBranch: assert property (p_afterBranch) // RULE_17
    else $error("source taken after delayed branch");

  property p_pushPc;
    @(posedge sys_clk) disable iff (!rstn)
    s.st == IEU_PUSH_PC |-> s.memWe
      && s.memAddr == s.spStart - `IEU_WORD_BYTES - `IEU_WORD_BYTES;
  endproperty
  a_pushPc: assert property (p_pushPc) // RULE_21
    else $error("return address push at wrong address");

  property p_fpVec;
    @(posedge sys_clk) disable iff (!rstn)
    ce && s.st == IEU_PUSH_PC && memAck && s.excPc == s.fpPc
      && s.excOfs == `IEU_FP_VEC_OFFSET
      |=> s.memAddr == $past(vectorBase) + `IEU_FP_VEC_OFFSET;
  endproperty
  a_fpVec: assert property (p_fpVec) // RULE_11
    else $error("fp vector address wrong");

endmodule : instruction_exception_unit

/* verilog/ieu_params.svh */
`ifndef IEU_PARAMS_SVH
`define IEU_PARAMS_SVH

// ==========================================================
// register map of the software port
`define IEU_OFS_FPSC 8'h00
`define IEU_OFS_EXCSTAT 8'h04

// ==========================================================
// fp event bit order inside every 5-bit field
`define IEU_EVT_V 0
`define IEU_EVT_Z 1
`define IEU_EVT_O 2
`define IEU_EVT_U 3
`define IEU_EVT_I 4
`define IEU_EVT_W 5

// field positions inside the fp status/control word
`define IEU_FPSC_CAUSE_LSB 0
`define IEU_FPSC_ENABLE_LSB 5
`define IEU_FPSC_FLAG_LSB 10
`define IEU_FPSC_RESET 5'h00

// ==========================================================
// fixed byte figures
`define IEU_WORD_BYTES 32'h4
`define IEU_INSTR_BYTES 32'h2
`define IEU_FP_VEC_OFFSET 32'h34
`define IEU_ZERO32 32'h0

`endif

/* verilog/ieu_pkg.sv */
// ==========================================================
// types shared by the exception unit
package ieu_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    IEU_IDLE,
    IEU_PUSH_SR,
    IEU_PUSH_PC,
    IEU_FETCH_VEC
  } ieu_state_t;

  // operation class reported by the fp datapath
  typedef enum logic [3:0] {
    IEU_FOP_ADD,
    IEU_FOP_SUB,
    IEU_FOP_MUL,
    IEU_FOP_DIV,
    IEU_FOP_MAC,
    IEU_FOP_CMPEQ,
    IEU_FOP_CMPGT,
    IEU_FOP_NEG,
    IEU_FOP_ABS,
    IEU_FOP_TRC,
    IEU_FOP_XFER
  } ieu_fpop_t;

  // complete state of the unit
  typedef struct packed {
    ieu_state_t st;
    logic [4:0] cause;
    logic [4:0] enable;
    logic [4:0] flags;
    logic prevDelayed;
    logic prevCtrl;
    logic prevFp;
    logic [31:0] slotTarget;
    logic pendBus;
    logic pendInt;
    logic [31:0] pendIntOfs;
    logic pendFp;
    logic [31:0] fpPc;
    logic [31:0] excPc;
    logic [31:0] excOfs;
    logic [31:0] spStart;
    logic excBusy;
    logic excFlush;
    logic fpuSuspend;
    logic memReq;
    logic memWe;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic pcLoad;
    logic [31:0] newPc;
    logic spLoad;
    logic [31:0] newSp;
    logic [31:0] rdata;
  } ieu_regs_t;

endpackage : ieu_pkg

/* tb/ieu_mem_model.sv */
// ==========================================================
// memory model: acks stack pushes and vector reads
module ieu_mem_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata,
  output logic [2:0][31:0] logAddr,
  output logic [2:0][31:0] logData,
  output logic [1:0] logN
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] waitCnt; // cycles waited on the current request

  // answers each request, promptly or after two extra cycles
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      memAck <= 1'b0;
      memRdata <= 32'h0;
      waitCnt <= 2'h0;
      logN <= 2'h0;
    end else begin
      memAck <= 1'b0;
      // read data is only valid with the ack, else it keeps changing
      memRdata <= ~memRdata;
      if (!memReq) begin
        logN <= 2'h0;
        waitCnt <= 2'h0;
      end else if (memAck) begin
        // transfer completes here, record what the unit showed
        logAddr[logN] <= memAddr;
        logData[logN] <= memWdata;
        logN <= logN + 2'h1;
        waitCnt <= 2'h0;
      end else if (waitCnt >= (slow ? 2'h2 : 2'h0)) begin
        memAck <= 1'b1;
        if (!memWe) begin
          memRdata <= memAddr + 32'h1000;
        end
      end else begin
        waitCnt <= waitCnt + 2'h1;
      end
    end
  end
endmodule : ieu_mem_model

/* tb/tb_top.sv */
// ==========================================================
// bench for the instruction exception unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ieu_pkg::*;

  localparam logic [31:0] GEN = 32'h10;
  localparam logic [31:0] SLOT = 32'h18;
  localparam logic [31:0] SR = 32'h000000f0;
  localparam logic [31:0] SP = 32'h00008000;
  localparam logic [31:0] VB = 32'h00001000;

  logic sys_clk, rstn, ce, decValid, decUndef, decIsTrap, decIsDelayed;
  logic decWritesPc, decIsCtrlLdSt, decIsFp, decIsFpRelated, fpuStop;
  logic busErr, intReq, fpuDone, regWrite, regRead, slow;
  logic [31:0] decPc, decBranchTarget, statusRegister, stackPointer;
  logic [31:0] vectorBase, fpuNextPc, regWdata;
  logic [7:0] decTrapVector, intVector, regAddr;
  logic [4:0] fpuEvt;
  ieu_fpop_t fpuOp;
  logic excBusy, excFlush, fpuSuspend, memReq, memWe, pcLoad, spLoad, memAck;
  logic [31:0] memAddr, memWdata, newPc, newSp, regRdata, memRdata;
  logic [2:0][31:0] logAddr, logData;
  logic [1:0] logN;
  int nMismatch, nTests, cyc;

  // ==========================================================
  // clock, design and memory
  always #50 sys_clk = ~sys_clk;

  instruction_exception_unit #(.GEN_ILL_OFS(GEN), .SLOT_ILL_OFS(SLOT)) dut (
    .sys_clk, .rstn, .ce, .decValid, .decPc, .decUndef, .decIsTrap,
    .decTrapVector, .decIsDelayed, .decBranchTarget, .decWritesPc,
    .decIsCtrlLdSt, .decIsFp, .decIsFpRelated, .fpuStop, .statusRegister,
    .stackPointer, .vectorBase, .busErr, .intReq, .intVector, .fpuDone,
    .fpuOp, .fpuEvt, .fpuNextPc, .memAck, .memRdata, .regAddr, .regWdata,
    .regWrite, .regRead, .excBusy, .excFlush, .fpuSuspend, .memReq, .memWe,
    .memAddr, .memWdata, .pcLoad, .newPc, .spLoad, .newSp, .regRdata);

  ieu_mem_model mem (.sys_clk, .rstn, .slow, .memReq, .memWe, .memAddr,
    .memWdata, .memAck, .memRdata, .logAddr, .logData, .logN);

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // decode flags f: {fp, ctrl, writesPc, delayed, trap, undef}
  task automatic dec(input logic [31:0] pc, input logic [5:0] f);
    @(posedge sys_clk);
    decValid <= 1'b1;
    decPc <= pc;
    {decIsFp, decIsCtrlLdSt, decWritesPc, decIsDelayed, decIsTrap,
      decUndef} <= f;
  endtask : dec

  // ends decoding and looks at the flush pulse
  task automatic idle(input logic expFlush);
    @(posedge sys_clk);
    decValid <= 1'b0;
    #1;
    check(32'(excFlush), 32'(expFlush));
  endtask : idle

  // waits for the handler load, then checks stack and vector
  task automatic excSeq(input logic [31:0] saved, input logic [31:0] vec);
    int n;
    n = 0;
    while (pcLoad !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(32'(logN), 32'h3);
    check(logAddr[0], SP - 32'h4);
    check(logData[0], SR);
    check(logAddr[1], SP - 32'h8);
    check(logData[1], saved);
    check(logAddr[2], vec);
    check(newPc, vec + 32'h1000);
    check(newSp, SP - 32'h8);
    check(32'(spLoad), 32'h1);
  endtask : excSeq

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic fop(input ieu_fpop_t op, input logic [4:0] ev,
                     input logic exp);
    @(posedge sys_clk);
    fpuDone <= 1'b1;
    fpuOp <= op;
    fpuEvt <= ev;
    @(posedge sys_clk);
    fpuDone <= 1'b0;
    #1;
    check(32'(fpuSuspend), 32'(exp));
  endtask : fop

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nMismatch++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {sys_clk, rstn, decValid, decUndef, decIsTrap, decIsDelayed} = '0;
    {decWritesPc, decIsCtrlLdSt, decIsFp, decIsFpRelated, fpuStop} = '0;
    {busErr, intReq, fpuDone, regWrite, regRead, slow} = '0;
    {decPc, regWdata, regAddr, fpuEvt, nMismatch, nTests, cyc} = '0;
    ce = 1'b1;
    fpuOp = IEU_FOP_ADD;
    decBranchTarget = 32'h400;
    statusRegister = SR;
    stackPointer = SP;
    vectorBase = VB;
    fpuNextPc = 32'h500;
    decTrapVector = 8'h21;
    intVector = 8'h30;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h60);
    fop(IEU_FOP_ADD, 5'h04, 1'b0);
    rd(8'h00, 32'h1064);
    fop(IEU_FOP_XFER, 5'h01, 1'b0);
    rd(8'h00, 32'h1461);
    wr(8'h00, 32'h40);
    fop(IEU_FOP_MUL, 5'h01, 1'b0);
    rd(8'h00, 32'h441);
    // a frozen clock enable must ignore a software write
    ce <= 1'b0;
    wr(8'h00, 32'h60);
    ce <= 1'b1;
    rd(8'h00, 32'h441);
    $display("fp status test done");
    // enabled divide event raised beside a delayed branch
    dec(32'h200, 6'h04);
    fpuDone <= 1'b1;
    fpuOp <= IEU_FOP_DIV;
    fpuEvt <= 5'h02;
    dec(32'h202, 6'h00);
    fpuDone <= 1'b0;
    dec(32'h400, 6'h00);
    #1 check(32'(excFlush), 32'h0);
    check(32'(fpuSuspend), 32'h1);
    idle(1'b1);
    excSeq(32'h500, VB + 32'h34);
    check(32'(fpuSuspend), 32'h0);
    rd(8'h00, 32'hc42);
    $display("fp exception test done");
    slow <= 1'b1;
    dec(32'h100, 6'h02);
    idle(1'b1);
    excSeq(32'h102, VB + 32'h84);
    slow <= 1'b0;
    $display("trap test done");
    dec(32'h120, 6'h01);
    idle(1'b1);
    excSeq(32'h120, VB + GEN);
    $display("illegal test done");
    for (int i = 0; i < 2; i++) begin
      dec(32'h140, 6'h04);
      dec(32'h142, (i == 0) ? 6'h01 : 6'h08);
      idle(1'b1);
      excSeq(32'h400, VB + SLOT);
    end
    $display("slot test done");
    // interrupt raised beside a control register access
    dec(32'h600, 6'h10);
    intReq <= 1'b1;
    dec(32'h602, 6'h00);
    intReq <= 1'b0;
    dec(32'h604, 6'h00);
    #1 check(32'(excFlush), 32'h0);
    idle(1'b1);
    excSeq(32'h604, VB + 32'hc0);
    $display("pending interrupt test done");
    // bus error raised beside an fp instruction
    dec(32'h700, 6'h20);
    busErr <= 1'b1;
    dec(32'h702, 6'h00);
    busErr <= 1'b0;
    dec(32'h704, 6'h00);
    #1 check(32'(excFlush), 32'h0);
    idle(1'b1);
    excSeq(32'h704, VB + 32'h24);
    $display("pending bus error test done");
    dec(32'h160, 6'h20);
    fpuStop <= 1'b1;
    idle(1'b1);
    excSeq(32'h160, VB + GEN);
    $display("fpu stop test done");
    summarize();
  end
endmodule : tb_top
